// [shared/sradc_pkg.sv]
// Shared constants and types of the serial converter readout block
`default_nettype none

package sradc_pkg;

  // ----------------------------------------------------------------
  // Clock and conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int T_CONV_MIN_NS = 1000;
  localparam int T_CONV_MAX_NS = 2000;
  localparam int T_CONV_NS     = 1500;
  // Least time rounds up, longest time rounds down
  localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_MAX_CYC  = (T_CONV_MAX_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Result word and readout counting
  // ----------------------------------------------------------------
  localparam int              RESULT_BITS = 18;
  localparam int              RESULT_MSB  = RESULT_BITS - 1;
  localparam logic [17:0]     RESULT_RST  = 18'h00000;
  localparam logic [4:0]      CNT_ZERO    = 5'h00;
  localparam logic [4:0]      CNT_ONE     = 5'h01;
  localparam logic [4:0]      CNT_LAST    = 5'h12;
  localparam logic [15:0]     TMR_ZERO    = 16'h0000;
  localparam logic [15:0]     TMR_ONE     = 16'h0001;

  // ----------------------------------------------------------------
  // Pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_W    = 3;
  localparam int LANE_CS   = 0;
  localparam int LANE_DIN  = 1;
  localparam int LANE_SCLK = 2;

  // Conversion phase
  typedef enum logic [0:0] {
    ST_ACQ  = 1'b0,
    ST_CONV = 1'b1
  } sradc_state_t;

endpackage : sradc_pkg

`default_nettype wire

// [design/sradc_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`default_nettype none
`timescale 1ns/1ps

module sradc_sync
  import sradc_pkg::*;
#(
  parameter int WIDTH = SYNC_W
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] lvl,
  output var  logic [WIDTH-1:0] rise,
  output var  logic [WIDTH-1:0] fall
);

  // ----------------------------------------------------------------
  // Per-lane stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_lane
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end
      else
      begin
        s1_r <= pin_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        lvl[i]  <= 1'b0;
        rise[i] <= 1'b0;
        fall[i] <= 1'b0;
      end
      else
      begin
        rise[i] <= (s2_r == s3_r) && s3_r && !lvl[i];
        fall[i] <= (s2_r == s3_r) && !s3_r && lvl[i];
        if (s2_r == s3_r)
          lvl[i] <= s3_r;
      end
    end
  end

endmodule : sradc_sync

`default_nettype wire

// [design/sradc_conv_timer.sv]
// Fixed-length conversion timer on the internal clock
`default_nettype none
`timescale 1ns/1ps

module sradc_conv_timer
  import sradc_pkg::*;
#(
  parameter int CONV_CYC = 150
)
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic start,
  output var  logic busy,
  output var  logic done
);

  // Load one short: done is registered, so the phase ends as the count runs out
  localparam logic [15:0] TMR_LOAD = 16'(CONV_CYC) - TMR_ONE;

  logic [15:0] cnt_r;

  // ----------------------------------------------------------------
  // Countdown; sclk and start rate never touch it
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= TMR_ZERO;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        cnt_r <= TMR_LOAD;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        cnt_r <= cnt_r - TMR_ONE;
        if (cnt_r == TMR_ONE)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : sradc_conv_timer

`default_nettype wire

// [design/sradc_readout.sv]
// Conversion sequencing and serial result readout of the converter
// What this block does
// - Data-in high at start selects chip-select mode
// - Data-in low at start selects daisy-chain
// - 3-wire start floats output, samples, converts
// - Conversion end enters acquisition, powers down
// - Start falling after conversion drives MSB
// - Later serial-clock falls present lower bits
// - 3-wire output floats at 18th fall or start
// - Select fall drives MSB; floats at 18/rise
// - Both lines low drives data out low
// - Daisy conversion end loads shifter, drives MSB
// - Daisy clock fall shifts data-in, next bit
// - Powered down acquiring, powers up converting
// - Previous result held for readout during acquisition
// - Conversion length independent of clock and rate
// - Result is a two's complement word
// - Serial clock used only for readout
`default_nettype none
`timescale 1ns/1ps

module sradc_readout
  import sradc_pkg::*;
#(
  parameter int CONV_NS = T_CONV_NS
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        conversion_start,
  input  wire logic        din,
  input  wire logic        sclk,
  input  wire logic [17:0] analog_code,
  output var  logic        dout,
  output var  logic        dout_oe,
  output var  logic        analog_powered,
  output var  logic        daisy_mode
);
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_lvl;
  logic [SYNC_W-1:0] pin_rise;
  logic [SYNC_W-1:0] pin_fall;

  sradc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_in ({sclk, din, conversion_start}),
    .lvl    (pin_lvl),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic din_lvl;
  logic din_rise;
  logic din_fall;
  logic sclk_fall;

  assign cs_lvl    = pin_lvl[LANE_CS];
  assign cs_rise   = pin_rise[LANE_CS];
  assign cs_fall   = pin_fall[LANE_CS];
  assign din_lvl   = pin_lvl[LANE_DIN];
  assign din_rise  = pin_rise[LANE_DIN];
  assign din_fall  = pin_fall[LANE_DIN];
  assign sclk_fall = pin_fall[LANE_SCLK];

  // ----------------------------------------------------------------
  // State and datapath registers
  // ----------------------------------------------------------------
  sradc_state_t state_r;
  logic [17:0]  sample_r;
  logic [17:0]  result_r;
  logic [17:0]  shift_r;
  logic [4:0]   bitcnt_r;
  logic         conv_start;
  logic         conv_done;
  logic         read_start;
  logic         read_shift;
  logic         daisy_shift;
  logic         low_drive;

  assign conv_start  = cs_rise && (state_r == ST_ACQ);
  // 3-wire: start falls; 4-wire: select falls with start high
  assign read_start  = (state_r == ST_ACQ) && !daisy_mode && din_lvl && cs_fall
                     || (state_r == ST_ACQ) && !daisy_mode && cs_lvl && din_fall;
  assign read_shift  = (state_r == ST_ACQ) && !daisy_mode && dout_oe && sclk_fall;
  assign daisy_shift = (state_r == ST_ACQ) && daisy_mode && cs_lvl && sclk_fall;
  assign low_drive   = !cs_lvl && !din_lvl;

  // ----------------------------------------------------------------
  // Conversion timing on the internal clock only
  // ----------------------------------------------------------------
  // fixed duration
  sradc_conv_timer #(
    .CONV_CYC (CONV_CYC)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .start  (conv_start),
    .busy   (),
    .done   (conv_done)
  );

  // ----------------------------------------------------------------
  // Phase sequencing and power
  // ----------------------------------------------------------------
  // phase and power
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r        <= ST_ACQ;
      analog_powered <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ACQ:
        begin
          if (conv_start)
          begin
            state_r        <= ST_CONV;
            analog_powered <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            state_r        <= ST_ACQ;
            analog_powered <= 1'b0;
          end
        end
        default:
        begin
          state_r        <= ST_ACQ;
          analog_powered <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      daisy_mode <= 1'b0;
    else if (conv_start)
      daisy_mode <= !din_lvl;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sample_r <= RESULT_RST;
    else if (conv_start)
      sample_r <= analog_code;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      result_r <= RESULT_RST;
    else if (conv_done)
      result_r <= sample_r;
  end

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  // shifter on sclk falls
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_r  <= RESULT_RST;
      bitcnt_r <= CNT_ZERO;
    end
    else if (conv_done)
    begin
      shift_r  <= sample_r;
      bitcnt_r <= CNT_ZERO;
    end
    else if (read_start)
    begin
      shift_r  <= result_r;
      bitcnt_r <= CNT_ONE;
    end
    else if (read_shift || daisy_shift)
    begin
      shift_r  <= {shift_r[RESULT_MSB-1:0], din_lvl};
      bitcnt_r <= bitcnt_r + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Data out pin drive
  // ----------------------------------------------------------------
  // output drive
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end
    else if (low_drive)
    begin
      dout    <= 1'b0;
      dout_oe <= 1'b1;
    end
    else if (conv_start)
      dout_oe <= !din_lvl;
    else if (conv_done && daisy_mode)
      dout <= sample_r[RESULT_MSB];
    else if (daisy_shift)
      dout <= shift_r[RESULT_MSB-1];
    else if (!daisy_mode && (cs_rise || din_rise))
      dout_oe <= 1'b0;
    else if (read_start)
    begin
      dout    <= result_r[RESULT_MSB];
      dout_oe <= 1'b1;
    end
    else if (read_shift)
    begin
      if (bitcnt_r == CNT_LAST)
        dout_oe <= 1'b0;
      else
        dout <= shift_r[RESULT_MSB-1];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] elapsed_r;

  // Cycles since the conversion began
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      elapsed_r <= TMR_ZERO;
    else if (conv_start)
      elapsed_r <= TMR_ONE;
    else if (state_r == ST_CONV)
      elapsed_r <= elapsed_r + TMR_ONE;
  end

  property p_mode_cs;
    @(posedge clk) disable iff (!resetn)
      conv_start && din_lvl |=> !daisy_mode && !dout_oe;
  endproperty
  a_mode_cs: assert property (p_mode_cs) else $error("chip-select start left output on");

  property p_mode_daisy;
    @(posedge clk) disable iff (!resetn)
      conv_start && !din_lvl |=> daisy_mode && state_r == ST_CONV;
  endproperty
  a_mode_daisy: assert property (p_mode_daisy) else $error("daisy mode not taken");

  property p_power;
    @(posedge clk) disable iff (!resetn)
      conv_start |=> analog_powered throughout (state_r == ST_CONV) [*2];
  endproperty
  a_power: assert property (p_power) else $error("not powered while converting");

  property p_power_down;
    @(posedge clk) disable iff (!resetn)
      conv_done |=> !analog_powered && state_r == ST_ACQ && result_r == $past(sample_r);
  endproperty
  a_power_down: assert property (p_power_down) else $error("no power down at conversion end");

  property p_read_msb;
    @(posedge clk) disable iff (!resetn)
      read_start && !low_drive |=> dout_oe && dout == $past(result_r[RESULT_MSB]);
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("MSB not presented on select");

  property p_float_last;
    @(posedge clk) disable iff (!resetn)
      read_shift && bitcnt_r == CNT_LAST && !low_drive |=> !dout_oe;
  endproperty
  a_float_last: assert property (p_float_last) else $error("output not floated after last bit");

  property p_next_bit;
    @(posedge clk) disable iff (!resetn)
      read_shift && bitcnt_r != CNT_LAST && !low_drive && !din_rise
        |=> dout == $past(shift_r[RESULT_MSB-1]);
  endproperty
  a_next_bit: assert property (p_next_bit) else $error("wrong next bit");

  property p_low_drive;
    @(posedge clk) disable iff (!resetn)
      low_drive |=> dout_oe && !dout;
  endproperty
  a_low_drive: assert property (p_low_drive) else $error("output not driven low");

  property p_daisy_load;
    @(posedge clk) disable iff (!resetn)
      conv_done && daisy_mode && !low_drive |=> shift_r == $past(sample_r) && dout == shift_r[RESULT_MSB];
  endproperty
  a_daisy_load: assert property (p_daisy_load) else $error("daisy load wrong");

  property p_daisy_shift;
    @(posedge clk) disable iff (!resetn)
      daisy_shift && !low_drive |=> shift_r[0] == $past(din_lvl) && dout == shift_r[RESULT_MSB];
  endproperty
  a_daisy_shift: assert property (p_daisy_shift) else $error("daisy shift wrong");

  property p_conv_len;
    @(posedge clk) disable iff (!resetn)
      conv_done |-> elapsed_r >= 16'(CONV_MIN_CYC) && elapsed_r <= 16'(CONV_MAX_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length out of bounds");

endmodule : sradc_readout

`default_nettype wire

// [test/sradc_host.sv]
// Host controller model driving the converter's serial pins
`default_nettype none
`timescale 1ns/1ps

module sradc_host
  import sradc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        dout,
  input  wire logic        dout_oe,
  output var  logic        conversion_start,
  output var  logic        din,
  output var  logic        sclk,
  output var  logic [35:0] word,
  output var  logic        word_valid
);
  // ----------------------------------------------------------------
  // Pin driving and capture
  // ----------------------------------------------------------------
  localparam int HALF = 8;  // Half of the 160 ns serial period
  logic last_r;
  logic line;

  // Floating line shows the inverse of its last level
  always @(posedge clk)
    if (dout_oe === 1'b1)
      last_r <= dout;
  assign line = (dout_oe === 1'b1) ? dout : ~last_r;

  // Idle pin levels
  initial
  begin
    conversion_start = 1'b0;
    din              = 1'b0;
    sclk             = 1'b0;
    word             = 36'h0;
    word_valid       = 1'b0;
    last_r           = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic begin_conv(input logic sel_level);
    conversion_start = 1'b0;
    din              = sel_level;
    sclk             = 1'b0;
    idle(6);
    conversion_start = 1'b1;
    idle(20);
  endtask : begin_conv

  task automatic end_conv(input int m);
    sclk = 1'b1;
    idle(HALF);
    sclk = 1'b0;
    if (m == 0)
      conversion_start = 1'b0;
    if (m == 1)
      din = 1'b0;
    idle(20);
    conversion_start = 1'b1;
    din              = (m != 2);
    idle(CONV_MAX_CYC);
  endtask : end_conv

  task automatic select(input int m);
    if (m == 0)
      conversion_start = 1'b0;
    else
      din = 1'b0;
  endtask : select

  task automatic deselect;
    din = 1'b1;
    idle(HALF);
  endtask : deselect

  // capture each bit on the high phase
  task automatic read(input int nb, input logic daisy, input logic [17:0] chain);
    word = 36'h0;
    idle(HALF);
    for (int i = 0; i < nb; i++)
    begin
      if (daisy)
        din = (i < 18) ? chain[17 - i] : 1'b0;
      sclk = 1'b1;
      idle(HALF);
      word = {word[34:0], line};
      sclk = 1'b0;
      idle(HALF);
    end
    word_valid = 1'b1;
    idle(1);
    word_valid = 1'b0;
  endtask : read

endmodule : sradc_host

`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench of the converter readout block
`default_nettype none
`timescale 1ns/1ps

module testbench
  import sradc_pkg::*;
;
  // ----------------------------------------------------------------
  // Clock, reset, design and host
  // ----------------------------------------------------------------
  localparam int CNS  = 1000;
  localparam int CCYC = CNS * CLK_MHZ / 1000;
  logic        clk;
  logic        resetn;
  logic        conv_start;
  logic        din;
  logic        sclk;
  logic        dout;
  logic        dout_oe;
  logic        powered;
  logic        daisy;
  logic        wv;
  logic [17:0] code;
  logic [17:0] v;
  logic [17:0] ch;
  logic [35:0] word;
  logic [35:0] exp_q[$];
  int          err_total;
  int          checks;
  int          seed;
  int          pw;

  sradc_readout #(.CONV_NS(CNS)) i_sradc_readout (
    .clk(clk), .resetn(resetn), .conversion_start(conv_start), .din(din),
    .sclk(sclk), .analog_code(code), .dout(dout), .dout_oe(dout_oe),
    .analog_powered(powered), .daisy_mode(daisy));

  sradc_host i_sradc_host (
    .clk(clk), .dout(dout), .dout_oe(dout_oe), .conversion_start(conv_start),
    .din(din), .sclk(sclk), .word(word), .word_valid(wv));

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] seen);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // Compare each read word with the oldest note
  always @(posedge clk)
    if (wv === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected word", 36'h0, word);
      else
        check("read word", exp_q.pop_front(), word);
    end

  // Length of each powered conversion
  always @(posedge clk)
    if (powered === 1'b1)
      pw <= pw + 1;
    else if (pw != 0)
    begin
      check("conversion cycles", CCYC, pw);
      pw <= 0;
    end

  // Main sequence over all three interface modes
  initial
  begin
    resetn    = 1'b0;
    code      = 18'h0;
    err_total = 0;
    checks    = 0;
    pw        = 0;
    seed      = 32'h3d34;
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    i_sradc_host.idle(10);
    check("dout_oe both low", 1, dout_oe);
    check("dout both low", 0, dout);
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 3; m++)
      begin
        v    = 18'($random(seed));
        ch   = 18'($random(seed));
        code = v;
        i_sradc_host.begin_conv(m != 2);
        code = ~v;
        check("dout_oe converting", (m == 2), dout_oe);
        check("powered converting", 1, powered);
        i_sradc_host.end_conv(m);
        check("powered acquiring", 0, powered);
        check("daisy_mode", (m == 2), daisy);
        exp_q.push_back((m == 2) ? {v, ch} : {18'h0, v});
        i_sradc_host.select(m);
        i_sradc_host.read((m == 2) ? 36 : 18, m == 2, ch);
        check("dout_oe after read", (m == 2), dout_oe);
        if (m == 1)
        begin
          i_sradc_host.deselect();
          exp_q.push_back({27'h0, v[17:9]});
          i_sradc_host.select(m);
          i_sradc_host.read(9, 1'b0, ch);
          i_sradc_host.deselect();
          check("dout_oe on deselect", 0, dout_oe);
        end
        $display("Test mode %0d pass %0d done", m, r);
      end
    i_sradc_host.idle(4);
    check("words left over", 0, exp_q.size());
    finish_test();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    finish_test();
  end

endmodule : testbench

`default_nettype wire
